// File: hdl/rhp_pkg.sv
// rhp_pkg: register map, bit positions and timing constants for the root hub port block
// assumes a 100 MHz system clock and a 32-bit apb register bus
package rhp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // port reset duration in microseconds, usb root port customary 10 ms
  localparam int unsigned RESET_TIME_US = 10000;
  localparam int unsigned RESET_CYCLES = RESET_TIME_US * CLK_MHZ;
  // resume signalling duration in microseconds (20 ms)
  localparam int unsigned RESUME_TIME_US = 20000;
  localparam int unsigned RESUME_CYCLES = RESUME_TIME_US * CLK_MHZ;

  localparam logic [11:0] PORT_STATUS_ADDR = 12'h000;
  localparam logic [11:0] PORT_CTRL_ADDR = 12'h004;

  // port status word bit positions
  localparam int unsigned BIT_ATTACHED = 0;
  localparam int unsigned BIT_ENABLED = 1;
  localparam int unsigned BIT_SUSPENDED = 2;
  localparam int unsigned BIT_OVERCURRENT = 3;
  localparam int unsigned BIT_RESET_ACTIVE = 4;
  localparam int unsigned BIT_ATTACH_CHANGE = 16;
  localparam int unsigned BIT_RESUME_DONE = 18;
  localparam int unsigned BIT_RESET_DONE = 20;
  // control word bit: per-port overcurrent reporting enable
  localparam int unsigned BIT_PER_PORT_OC = 0;

  localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0001;

  typedef enum logic [1:0] {
    RHP_IDLE,
    RHP_RESET,
    RHP_RESUME
  } rhp_state_e;
endpackage

// File: hdl/rhp_sync.sv
// rhp_sync: two flip-flop synchroniser for a level from outside the clock domain
// assumes the level is stable for several clock cycles
module rhp_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // rhp_sync

// File: hdl/rhp_timer.sv
// rhp_timer: down counter that pulses done after a loaded number of cycles
// assumes load is a one-cycle pulse from logic on the same clock
module rhp_timer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      cnt_reg <= cnt_reg - WIDTH'(1);
      done <= (cnt_reg == WIDTH'(1));
      busy <= (cnt_reg != WIDTH'(1));
    end else begin
      done <= 1'b0;
    end
  end
endmodule // rhp_timer

// File: hdl/rhp_port.sv
// rhp_port: root hub port reset, resume and overcurrent status with apb registers
// assumes attach/overcurrent pins are asynchronous; enable/suspend set requests come from logic on sys_clk
//
// Contract
// R1: overcurrent bit reads 0 without per-port reporting
// R2: overcurrent bit follows the overcurrent input
// R3: writing 1 starts resume, 0 ignored
// R4: resume starts only while port is suspended
// R5: writing 1 sets reset active and signals reset
// R6: reset done clears active, sets done flag together
// R7: reset on unattached port sets attach change instead
// R8: reset completion also sets port enabled
// R9: suspended cleared at resume end and reset end
// R10: internal timer ends reset without software help
//
// Implementation choices: the address map and the APB register port.
module rhp_port #(
  parameter int unsigned RESET_CYCLES = rhp_pkg::RESET_CYCLES,
  parameter int unsigned RESUME_CYCLES = rhp_pkg::RESUME_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic attach_pin,
  input wire logic overcurrent_pin,
  input wire logic suspend_request,
  input wire logic enable_request,
  output logic port_reset_drive,
  output logic port_resume_drive
);
  ////////////////////////////////////////////////////////////////////////
  logic device_attached;
  logic oc_sync;
  logic port_enabled_reg;
  logic port_suspended_reg;
  logic port_reset_active_reg;
  logic attach_change_flag_reg;
  logic reset_done_flag_reg;
  logic resume_done_flag_reg;
  logic attach_prev_reg;
  logic [31:0] ctrl_reg;
  logic port_overcurrent_flag;
  rhp_pkg::rhp_state_e state_reg;
  logic tmr_load;
  logic [31:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;
  logic wr_en;
  logic rd_en;
  logic resume_command;
  logic reset_start_command;
  logic reset_end;
  logic resume_end;
  logic reset_accepted;
  logic resume_accepted;
  logic [31:0] status_word;

  rhp_sync u_sync_attach (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(attach_pin),
    .sync_out(device_attached)
  );

  rhp_sync u_sync_oc (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(overcurrent_pin),
    .sync_out(oc_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, every access answered in its access phase
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  // a write of 1 in the status word doubles as the command bit
  assign resume_command = wr_en && addr_hit(paddr, rhp_pkg::PORT_STATUS_ADDR)
    && pwdata[rhp_pkg::BIT_OVERCURRENT]; // see R3
  assign reset_start_command = wr_en && addr_hit(paddr, rhp_pkg::PORT_STATUS_ADDR)
    && pwdata[rhp_pkg::BIT_RESET_ACTIVE]; // see R5
  assign port_overcurrent_flag = ctrl_reg[rhp_pkg::BIT_PER_PORT_OC] && oc_sync; // see R1 see R2
  // reset takes priority over a resume written in the same word
  assign reset_accepted = reset_start_command && device_attached && (state_reg == rhp_pkg::RHP_IDLE); // see R7
  assign resume_accepted = resume_command && !reset_start_command && port_suspended_reg
    && (state_reg == rhp_pkg::RHP_IDLE); // see R4
  assign reset_end = tmr_done && (state_reg == rhp_pkg::RHP_RESET);
  assign resume_end = tmr_done && (state_reg == rhp_pkg::RHP_RESUME);
  assign tmr_load = reset_accepted || resume_accepted;
  // done lands one edge before the drive falls, so load one less; counts below two are not supported
  assign tmr_count = reset_accepted ? 32'(RESET_CYCLES - 1) : 32'(RESUME_CYCLES - 1);

  rhp_timer #(.WIDTH(32)) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always_comb begin
    status_word = '0;
    status_word[rhp_pkg::BIT_ATTACHED] = device_attached;
    status_word[rhp_pkg::BIT_ENABLED] = port_enabled_reg;
    status_word[rhp_pkg::BIT_SUSPENDED] = port_suspended_reg;
    status_word[rhp_pkg::BIT_OVERCURRENT] = port_overcurrent_flag; // see R1 see R2
    status_word[rhp_pkg::BIT_RESET_ACTIVE] = port_reset_active_reg;
    status_word[rhp_pkg::BIT_ATTACH_CHANGE] = attach_change_flag_reg;
    status_word[rhp_pkg::BIT_RESUME_DONE] = resume_done_flag_reg;
    status_word[rhp_pkg::BIT_RESET_DONE] = reset_done_flag_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_hit(paddr, rhp_pkg::PORT_STATUS_ADDR)
        && !addr_hit(paddr, rhp_pkg::PORT_CTRL_ADDR);
      if (rd_en) begin
        if (addr_hit(paddr, rhp_pkg::PORT_STATUS_ADDR)) begin
          prdata <= status_word;
        end else if (addr_hit(paddr, rhp_pkg::PORT_CTRL_ADDR)) begin
          prdata <= ctrl_reg;
        end else begin
          prdata <= '0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= rhp_pkg::CTRL_RESET_VALUE;
    end else if (wr_en && addr_hit(paddr, rhp_pkg::PORT_CTRL_ADDR)) begin
      ctrl_reg <= pwdata & rhp_pkg::CTRL_RESET_VALUE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= rhp_pkg::RHP_IDLE;
    end else begin
      case (state_reg)
        rhp_pkg::RHP_IDLE: begin
          if (reset_accepted) begin
            state_reg <= rhp_pkg::RHP_RESET; // see R5
          end else if (resume_accepted) begin
            state_reg <= rhp_pkg::RHP_RESUME; // see R4
          end
        end
        rhp_pkg::RHP_RESET: begin
          if (reset_end) begin
            state_reg <= rhp_pkg::RHP_IDLE; // see R10
          end
        end
        rhp_pkg::RHP_RESUME: begin
          if (resume_end) begin
            state_reg <= rhp_pkg::RHP_IDLE;
          end
        end
        default: begin
          state_reg <= rhp_pkg::RHP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_reset_active_reg <= 1'b0;
    end else if (reset_accepted) begin
      port_reset_active_reg <= 1'b1; // see R5
    end else if (reset_end) begin
      port_reset_active_reg <= 1'b0; // see R6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_reset_drive <= 1'b0;
      port_resume_drive <= 1'b0;
    end else begin
      port_reset_drive <= (reset_accepted || port_reset_active_reg) && !reset_end; // see R5
      port_resume_drive <= (resume_accepted || state_reg == rhp_pkg::RHP_RESUME) && !resume_end; // see R3
    end
  end

  // change flags: write 1 to clear, but a set in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_done_flag_reg <= 1'b0;
      resume_done_flag_reg <= 1'b0;
      attach_change_flag_reg <= 1'b0;
      attach_prev_reg <= 1'b0;
    end else begin
      attach_prev_reg <= device_attached;
      if (reset_end) begin
        reset_done_flag_reg <= 1'b1; // see R6
      end else if (wr_en && addr_hit(paddr, rhp_pkg::PORT_STATUS_ADDR) && pwdata[rhp_pkg::BIT_RESET_DONE]) begin
        reset_done_flag_reg <= 1'b0;
      end
      if (resume_end) begin
        resume_done_flag_reg <= 1'b1;
      end else if (wr_en && addr_hit(paddr, rhp_pkg::PORT_STATUS_ADDR) && pwdata[rhp_pkg::BIT_RESUME_DONE]) begin
        resume_done_flag_reg <= 1'b0;
      end
      if ((reset_start_command && !device_attached) || (attach_prev_reg != device_attached)) begin
        attach_change_flag_reg <= 1'b1; // see R7
      end else if (wr_en && addr_hit(paddr, rhp_pkg::PORT_STATUS_ADDR) && pwdata[rhp_pkg::BIT_ATTACH_CHANGE]) begin
        attach_change_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_enabled_reg <= 1'b0;
    end else if (reset_end) begin
      port_enabled_reg <= 1'b1; // see R8
    end else if (!device_attached) begin
      port_enabled_reg <= 1'b0;
    end else if (enable_request) begin
      port_enabled_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_suspended_reg <= 1'b0;
    end else if (reset_end || resume_end) begin
      port_suspended_reg <= 1'b0; // see R9
    end else if (suspend_request && device_attached && state_reg == rhp_pkg::RHP_IDLE) begin
      port_suspended_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // drive lengths, read only by the duration checks
  logic [31:0] reset_len_reg;
  logic [31:0] resume_len_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_len_reg <= '0;
      resume_len_reg <= '0;
    end else begin
      reset_len_reg <= port_reset_drive ? reset_len_reg + 32'h0000_0001 : '0;
      resume_len_reg <= port_resume_drive ? resume_len_reg + 32'h0000_0001 : '0;
    end
  end

  a_reset_length: assert property (@(posedge sys_clk) disable iff (rst) // see R10
    ($fell(port_reset_drive) && !$past(rst)) |-> reset_len_reg == 32'(RESET_CYCLES))
    else $error("reset signalling length wrong");
  a_resume_length: assert property (@(posedge sys_clk) disable iff (rst) // see R3
    ($fell(port_resume_drive) && !$past(rst)) |-> resume_len_reg == 32'(RESUME_CYCLES))
    else $error("resume signalling length wrong");
  a_reset_sets_active: assert property (@(posedge sys_clk) disable iff (rst) // see R5
    reset_accepted |=> port_reset_active_reg && port_reset_drive)
    else $error("reset command did not start reset");
  a_reset_unattached: assert property (@(posedge sys_clk) disable iff (rst) // see R7
    (reset_start_command && !device_attached) |=> !$rose(port_reset_active_reg) && attach_change_flag_reg)
    else $error("reset on unattached port misbehaved");
  a_reset_done_pair: assert property (@(posedge sys_clk) disable iff (rst) // see R6
    $fell(port_reset_active_reg) |-> $rose(reset_done_flag_reg) || reset_done_flag_reg)
    else $error("reset active fell without done flag");
  a_reset_enables: assert property (@(posedge sys_clk) disable iff (rst) // see R8
    reset_end |=> port_enabled_reg && !port_suspended_reg)
    else $error("reset end did not enable port");
  a_resume_needs_susp: assert property (@(posedge sys_clk) disable iff (rst) // see R4
    (resume_command && !port_suspended_reg && state_reg == rhp_pkg::RHP_IDLE) |=> state_reg != rhp_pkg::RHP_RESUME)
    else $error("resume started while not suspended");
  a_resume_clears_susp: assert property (@(posedge sys_clk) disable iff (rst) // see R9
    resume_end |=> !port_suspended_reg && resume_done_flag_reg)
    else $error("resume end left port suspended");
  a_oc_follows: assert property (@(posedge sys_clk) disable iff (rst) // see R2
    (ctrl_reg[rhp_pkg::BIT_PER_PORT_OC] && !$past(rst, 1) && !$past(rst, 2))
      |-> status_word[rhp_pkg::BIT_OVERCURRENT] == $past(overcurrent_pin, 2))
    else $error("overcurrent flag does not follow input");
  a_oc_zero_global: assert property (@(posedge sys_clk) disable iff (rst) // see R1
    !ctrl_reg[rhp_pkg::BIT_PER_PORT_OC] |-> !status_word[rhp_pkg::BIT_OVERCURRENT])
    else $error("overcurrent bit set without per-port reporting");
  a_reset_timed_end: assert property (@(posedge sys_clk) disable iff (rst) // see R10
    $rose(port_reset_active_reg) |-> tmr_busy)
    else $error("reset started without timer");
  c_reset_done: cover property (@(posedge sys_clk) disable iff (rst) reset_end);
  c_resume_done: cover property (@(posedge sys_clk) disable iff (rst) resume_end);
  c_reset_unattached: cover property (@(posedge sys_clk) disable iff (rst) reset_start_command && !device_attached);
  c_oc_seen: cover property (@(posedge sys_clk) disable iff (rst) port_overcurrent_flag);
  c_reset_over_resume: cover property (@(posedge sys_clk) disable iff (rst) reset_accepted && resume_command);
endmodule // rhp_port

// File: tb/rhp_dev_model.sv
// rhp_dev_model: attached usb device as seen from the root hub port pins
// assumes the bench plugs and faults it through plug_in and oc_event, all on sys_clk
module rhp_dev_model (
  input wire logic sys_clk,
  input wire logic plug_in,
  input wire logic oc_event,
  input wire logic port_reset_drive,
  input wire logic port_resume_drive,
  output logic attach_pin,
  output logic overcurrent_pin,
  output logic [31:0] reset_len,
  output logic [31:0] resume_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rst_cnt = 32'h0;
  logic [31:0] res_cnt = 32'h0;
  initial reset_len = 32'h0;
  initial resume_len = 32'h0;
  assign attach_pin = plug_in;
  // supply fault, not tied to attach
  assign overcurrent_pin = oc_event;
  ////////////////////////////////////////////////////////////////////////////////
  // length of reset signalling, reported once it ends
  always @(posedge sys_clk) begin
    if (port_reset_drive === 1'b1) rst_cnt <= rst_cnt + 32'h1;
    else if (rst_cnt != 32'h0) begin
      reset_len <= rst_cnt;
      rst_cnt <= 32'h0;
    end
  end
  always @(posedge sys_clk) begin
    if (port_resume_drive === 1'b1) res_cnt <= res_cnt + 32'h1;
    else if (res_cnt != 32'h0) begin
      resume_len <= res_cnt;
      res_cnt <= 32'h0;
    end
  end
endmodule // rhp_dev_model

// File: tb/tb.sv
// tb: self-checking bench for rhp_port over apb, with a device model on the port pins
// assumes short reset and resume counts given as parameters
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RST_N = 20;
  localparam int unsigned RES_N = 30;
  localparam logic [11:0] ST = rhp_pkg::PORT_STATUS_ADDR;
  localparam logic [11:0] CT = rhp_pkg::PORT_CTRL_ADDR;
  logic sys_clk, rst, psel, penable, pwrite, suspend_request, enable_request, plug_in, oc_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, w, reset_len, resume_len;
  logic pready, pslverr, err, attach_pin, overcurrent_pin, port_reset_drive, port_resume_drive, c, o;
  logic e_att, e_en, e_sus, e_oc, e_ra, e_ac, e_rdn, e_rsd;
  int failures = 0;
  int tests_run = 0;
  rhp_port #(.RESET_CYCLES(RST_N), .RESUME_CYCLES(RES_N)) rhp_port_i (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .attach_pin(attach_pin), .overcurrent_pin(overcurrent_pin),
    .suspend_request(suspend_request), .enable_request(enable_request),
    .port_reset_drive(port_reset_drive), .port_resume_drive(port_resume_drive));
  rhp_dev_model rhp_dev_model_i (.sys_clk(sys_clk), .plug_in(plug_in), .oc_event(oc_event),
    .port_reset_drive(port_reset_drive), .port_resume_drive(port_resume_drive), .attach_pin(attach_pin),
    .overcurrent_pin(overcurrent_pin), .reset_len(reset_len), .resume_len(resume_len));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] exp_st();
    logic [31:0] r;
    r = 32'h0;
    r[rhp_pkg::BIT_ATTACHED] = e_att;
    r[rhp_pkg::BIT_ENABLED] = e_en;
    r[rhp_pkg::BIT_SUSPENDED] = e_sus;
    r[rhp_pkg::BIT_OVERCURRENT] = e_oc;
    r[rhp_pkg::BIT_RESET_ACTIVE] = e_ra;
    r[rhp_pkg::BIT_ATTACH_CHANGE] = e_ac;
    r[rhp_pkg::BIT_RESUME_DONE] = e_rdn;
    r[rhp_pkg::BIT_RESET_DONE] = e_rsd;
    return r;
  endfunction
  // master holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      results();
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic pulse_suspend();
    suspend_request <= 1'b1;
    @(posedge sys_clk);
    suspend_request <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((port_reset_drive | port_resume_drive) !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300) begin
      failures++;
      results();
    end
  endtask
  task automatic do_reset();
    apb(1'b1, ST, (32'h1 << rhp_pkg::BIT_RESET_ACTIVE) | (32'h1 << rhp_pkg::BIT_OVERCURRENT));
    e_ra = 1'b1;
    rd_chk(ST, exp_st());
    chk({31'h0, port_reset_drive}, 32'h1);
    chk({31'h0, port_resume_drive}, 32'h0);
    wait_idle();
    {e_ra, e_rsd, e_en, e_sus} = 4'b0110;
    rd_chk(ST, exp_st());
    chk(reset_len, RST_N);
    apb(1'b1, ST, 32'h1 << rhp_pkg::BIT_RESET_DONE);
    e_rsd = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    results();
  end
  initial begin
    {rst, psel, penable, pwrite, suspend_request, enable_request, plug_in, oc_event} = 8'h80;
    paddr = 12'h0; pwdata = 32'h0;
    {e_att, e_en, e_sus, e_oc, e_ra, e_ac, e_rdn, e_rsd} = 8'h0;
    void'($urandom(83));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(ST, exp_st());
    rd_chk(CT, rhp_pkg::CTRL_RESET_VALUE);
    apb(1'b0, 12'h008, 32'h0);
    chk({q[30:0], err}, 32'h1);
    // reset attempt with nothing attached
    apb(1'b1, ST, 32'h1 << rhp_pkg::BIT_RESET_ACTIVE);
    e_ac = 1'b1;
    rd_chk(ST, exp_st());
    chk({31'h0, port_reset_drive}, 32'h0);
    plug_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    e_att = 1'b1;
    apb(1'b1, ST, 32'h1 << rhp_pkg::BIT_ATTACH_CHANGE);
    e_ac = 1'b0;
    rd_chk(ST, exp_st());
    // zeros in the command bits change nothing
    repeat (4) begin
      w = $urandom & ~32'h0015_0018;
      apb(1'b1, ST, w);
      rd_chk(ST, exp_st());
    end
    do_reset();
    // resume while not suspended is ignored
    apb(1'b1, ST, 32'h1 << rhp_pkg::BIT_OVERCURRENT);
    rd_chk(ST, exp_st());
    chk({31'h0, port_resume_drive}, 32'h0);
    pulse_suspend();
    e_sus = 1'b1;
    apb(1'b1, ST, 32'h1 << rhp_pkg::BIT_OVERCURRENT);
    rd_chk(ST, exp_st());
    chk({31'h0, port_resume_drive}, 32'h1);
    wait_idle();
    {e_sus, e_rdn} = 2'b01;
    rd_chk(ST, exp_st());
    chk(resume_len, RES_N);
    apb(1'b1, ST, 32'h1 << rhp_pkg::BIT_RESUME_DONE);
    e_rdn = 1'b0;
    pulse_suspend();
    e_sus = 1'b1;
    do_reset();
    // first two passes pin the corners, the rest are random
    for (int i = 0; i < 8; i++) begin
      c = (i < 2) ? i[0] : 1'($urandom);
      o = (i < 2) ? 1'b1 : 1'($urandom);
      apb(1'b1, CT, {31'h0, c});
      oc_event <= o;
      repeat (5) @(posedge sys_clk);
      e_oc = o & c;
      rd_chk(ST, exp_st());
      rd_chk(CT, {31'h0, c});
    end
    oc_event <= 1'b0;
    plug_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    enable_request <= 1'b1;
    @(posedge sys_clk);
    enable_request <= 1'b0;
    {e_att, e_en, e_oc, e_ac} = 4'b0001;
    rd_chk(ST, exp_st());
    results();
  end
endmodule // tb
